// >>> shared/phv_pkg.sv
// Constants, register map and helpers for the PLL holdover and VCO calibration block.
// Assumes one 20 MHz clock and a byte-wide internal register port from the serial control port.
package phv_pkg;
    // Register offsets
    localparam logic [9:0] ADDR_LDCAL  = 10'h018;
    localparam logic [9:0] ADDR_LDPIN  = 10'h01a;
    localparam logic [9:0] ADDR_REFSEL = 10'h01c;
    localparam logic [9:0] ADDR_HOLD   = 10'h01d;
    localparam logic [9:0] ADDR_STAT   = 10'h01f;
    localparam logic [9:0] ADDR_VDIV   = 10'h1e0;
    localparam logic [9:0] ADDR_UPD    = 10'h232;
    localparam logic [7:0] REG_RESET   = 8'h00;
    localparam int         NUM_RW      = 6;

    // Field positions
    localparam int CAL_BIT      = 0;
    localparam int CALDIV_LSB   = 1;
    localparam int LKD_DIS_BIT  = 3;
    localparam int LKD_WIN_BIT  = 4;
    localparam int LDCNT_LSB    = 5;
    localparam int LDMODE_LSB   = 0;
    localparam int MON_EXT_BIT  = 6;
    localparam int REFBUF_LSB   = 1;
    localparam int REF_PREF_BIT = 3;
    localparam int REF_AUTO_BIT = 4;
    localparam int HOLD_EN_BIT  = 0;
    localparam int HOLD_EXT_BIT = 1;
    localparam int HOLD_CMP_BIT = 3;
    localparam int UPD_BIT      = 0;
    localparam int VDIV_LSB     = 0;

    localparam logic [5:0] LDMODE_CURSRC = 6'h04;

    // Lock detect counts per counter code
    localparam logic [7:0] LOCK_CNT_00 = 8'h05;
    localparam logic [7:0] LOCK_CNT_01 = 8'h10;
    localparam logic [7:0] LOCK_CNT_10 = 8'h40;
    localparam logic [7:0] LOCK_CNT_11 = 8'hff;

    // Calibration
    localparam logic [12:0] CAL_CYCLES = 13'h1130;
    localparam logic [4:0]  CAL_DIV_00 = 5'h02;
    localparam logic [4:0]  CAL_DIV_01 = 5'h04;
    localparam logic [4:0]  CAL_DIV_10 = 5'h08;
    localparam logic [4:0]  CAL_DIV_11 = 5'h10;

    // Frequency monitor window and thresholds (edges per window)
    localparam int         CLK_PERIOD_NS = 50;
    localparam int         MON_WINDOW_NS = 51200;
    localparam logic [10:0] MON_WINDOW_CYC = 11'(MON_WINDOW_NS / CLK_PERIOD_NS);
    localparam logic [7:0] MON_THR_NORMAL = 8'h10;
    localparam logic [7:0] MON_THR_EXT    = 8'h04;

    function automatic logic [7:0] phv_lock_need(input logic [1:0] code);
        unique case (code)
            2'h0: phv_lock_need = LOCK_CNT_00;
            2'h1: phv_lock_need = LOCK_CNT_01;
            2'h2: phv_lock_need = LOCK_CNT_10;
            default: phv_lock_need = LOCK_CNT_11;
        endcase
    endfunction : phv_lock_need

    function automatic logic [4:0] phv_cal_div(input logic [1:0] code);
        unique case (code)
            2'h0: phv_cal_div = CAL_DIV_00;
            2'h1: phv_cal_div = CAL_DIV_01;
            2'h2: phv_cal_div = CAL_DIV_10;
            default: phv_cal_div = CAL_DIV_11;
        endcase
    endfunction : phv_cal_div
endpackage : phv_pkg

// >>> shared/phv_cal_if.sv
// Handshake between the register/holdover logic and the VCO calibration sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface phv_cal_if;
    logic       start;
    logic [1:0] div_sel;
    logic       ref_edge;
    logic       busy;
    logic       done;
    logic       output_sync;
    logic       loop_open;
    modport ctrl (output start, output div_sel, output ref_edge,
                  input busy, input done, input output_sync, input loop_open);
    modport cal  (input start, input div_sel, input ref_edge,
                  output busy, output done, output output_sync, output loop_open);
endinterface : phv_cal_if

// >>> src/phv_cal_seq.sv
// VCO calibration sequencer, ticking on divided phase detector events.
// Assumes ref_edge is a one-cycle pulse per reference-path phase detector event.
`timescale 1ns/1ns
module phv_cal_seq (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control side
    phv_cal_if.cal    cal
);
    import phv_pkg::*;

    typedef enum logic [2:0] {
        CS_IDLE  = 3'b001,
        CS_CAL   = 3'b010,
        CS_CLOSE = 3'b100
    } phv_cal_st_t;

    phv_cal_st_t st_q, st_d;
    logic [4:0]  div_q, div_d;
    logic [12:0] tick_q, tick_d;
    logic        done_q, done_d;
    logic        tick;

    // A tick needs reference events, so calibration stalls without reference
    assign tick = cal.ref_edge && (div_q == phv_cal_div(cal.div_sel) - 5'h01);

    always_comb begin
        st_d   = st_q;
        div_d  = div_q;
        tick_d = tick_q;
        done_d = done_q;
        if (cal.ref_edge) begin
            div_d = tick ? 5'h00 : div_q + 5'h01;
        end
        unique case (st_q)
            CS_IDLE: begin
                if (cal.start) begin
                    st_d   = CS_CAL;
                    div_d  = 5'h00;
                    tick_d = 13'h0000;
                    done_d = 1'b0;
                end
            end
            CS_CAL: begin
                if (tick) begin
                    tick_d = tick_q + 13'h0001;
                    // Sync released one tick before the loop closes
                    if (tick_q == CAL_CYCLES - 13'h0002) begin
                        st_d = CS_CLOSE;
                    end
                end
            end
            CS_CLOSE: begin
                if (tick) begin
                    st_d   = CS_IDLE;
                    done_d = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q   <= CS_IDLE;
            div_q  <= 5'h00;
            tick_q <= 13'h0000;
            done_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            div_q  <= div_d;
            tick_q <= tick_d;
            done_q <= done_d;
        end
    end

    assign cal.busy        = (st_q != CS_IDLE);
    assign cal.output_sync = (st_q == CS_CAL);
    assign cal.loop_open   = (st_q != CS_IDLE);
    assign cal.done        = done_q;

    // Checks
    logic [12:0] hlp_ticks_q;
    always_ff @(posedge clk) begin
        if (rst || cal.start) begin
            hlp_ticks_q <= 13'h0000;
        end else if (cal.busy && tick) begin
            hlp_ticks_q <= hlp_ticks_q + 13'h0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_started;
        (st_q == CS_IDLE) && cal.start;
    endsequence
    sequence s_syncing;
        cal.output_sync && !cal.done;
    endsequence

    a_sync_on_start: assert property (
        s_started |=> s_syncing)
        else $error("output sync not raised at calibration start");
    a_done_clears: assert property (
        s_started |=> !cal.done [*2])
        else $error("done flag not cleared by new calibration");
    a_release_then_close: assert property (
        $fell(cal.output_sync) |-> cal.loop_open && !cal.done)
        else $error("sync released after loop closed");
    a_cal_length: assert property (
        $fell(cal.busy) |-> hlp_ticks_q == CAL_CYCLES && cal.done)
        else $error("calibration length differs from nominal");
endmodule : phv_cal_seq

// >>> src/phv_pll_ctrl.sv
// PLL holdover, lock detect, frequency monitor and calibration control with its registers.
// Assumes phase detector and edge pulses come from logic on CLK; pin levels are asynchronous.
`timescale 1ns/1ns
module phv_pll_ctrl (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       RST,
    // Register port from the serial control port
    input  wire logic       REG_WR,
    input  wire logic [9:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    // Phase detector events
    input  wire logic       PFD_REF_EDGE,
    input  wire logic       PFD_IN_WINDOW,
    input  wire logic       PFD_OVER_UNLOCK,
    input  wire logic       REF_PRESENT,
    // Pins
    input  wire logic       LOCK_DETECT_PIN,
    input  wire logic       SYNC_PIN_N,
    // Frequency monitor inputs
    input  wire logic       PRI_REF_EDGE,
    input  wire logic       SEC_REF_EDGE,
    input  wire logic       VCO_EDGE,
    input  wire logic       CLKIN_EDGE,
    input  wire logic       CLKIN_SEL,
    // Loop controls
    output logic            CP_HIGHZ,
    output logic            B_COUNTER_RESET,
    output logic            DIGITAL_LOCK_DETECT,
    output logic            LOCK_WIN_HIGH,
    output logic            OUTPUT_SYNC,
    output logic            PLL_LOOP_OPEN,
    // Lock pin and reference controls
    output logic      [5:0] LOCK_PIN_MODE,
    output logic            LOCK_PIN_CUR_SRC,
    output logic            REF_AUTO_SWITCH,
    output logic            REF_PREFER_SECONDARY,
    output logic      [1:0] REF_BUF_EN,
    output logic      [2:0] VCO_DIV_SEL
);
    import phv_pkg::*;

    typedef enum logic [3:0] {
        HS_LOCKED = 4'b0001,
        HS_AUTO   = 4'b0010,
        HS_MANUAL = 4'b0100,
        HS_REARM  = 4'b1000
    } phv_hold_st_t;

    function automatic logic [2:0] reg_index(input logic [9:0] addr);
        unique case (addr)
            ADDR_LDCAL:  reg_index = 3'h0;
            ADDR_LDPIN:  reg_index = 3'h1;
            ADDR_REFSEL: reg_index = 3'h2;
            ADDR_HOLD:   reg_index = 3'h3;
            ADDR_VDIV:   reg_index = 3'h4;
            default:     reg_index = 3'h7;
        endcase
    endfunction : reg_index

    function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic en);
        sat_inc = (en && v != 8'hff) ? v + 8'h01 : v;
    endfunction : sat_inc

    // Register file: writes land in a shadow copy, update makes them active
    logic [7:0] shad_q [NUM_RW];
    logic [7:0] shad_d [NUM_RW];
    logic [7:0] act_q  [NUM_RW];
    logic [7:0] act_d  [NUM_RW];
    logic [7:0] rdata_q, rdata_d;
    logic       start_q, start_d;
    logic       upd;
    logic [2:0] widx;

    assign widx = reg_index(REG_ADDR);
    assign upd  = REG_WR && REG_ADDR == ADDR_UPD && REG_WDATA[UPD_BIT];

    always_comb begin
        shad_d = shad_q;
        act_d  = act_q;
        if (REG_WR && widx != 3'h7) begin
            shad_d[widx] = REG_WDATA;
        end
        if (upd) begin
            act_d = shad_q;
        end
        // Only a 0 to 1 change of the active cal bit starts a calibration
        start_d = upd && shad_q[0][CAL_BIT] && !act_q[0][CAL_BIT];
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            for (int i = 0; i < NUM_RW; i++) begin
                shad_q[i] <= REG_RESET;
                act_q[i]  <= REG_RESET;
            end
            start_q <= 1'b0;
        end else begin
            shad_q  <= shad_d;
            act_q   <= act_d;
            start_q <= start_d;
        end
    end

    logic [1:0] lock_code;
    logic       lkd_dis, hold_en, hold_ext, cmp_en, mon_ext;
    assign lock_code = act_q[0][LDCNT_LSB +: 2];
    assign lkd_dis   = act_q[0][LKD_DIS_BIT];
    assign mon_ext   = act_q[1][MON_EXT_BIT];
    assign hold_en   = act_q[3][HOLD_EN_BIT];
    assign hold_ext  = act_q[3][HOLD_EXT_BIT];
    assign cmp_en    = act_q[3][HOLD_CMP_BIT];

    assign LOCK_WIN_HIGH        = !act_q[0][LKD_WIN_BIT];
    assign LOCK_PIN_MODE        = act_q[1][LDMODE_LSB +: 6];
    assign LOCK_PIN_CUR_SRC     = LOCK_PIN_MODE == LDMODE_CURSRC;
    assign REF_AUTO_SWITCH      = act_q[2][REF_AUTO_BIT];
    assign REF_PREFER_SECONDARY = act_q[2][REF_PREF_BIT];
    assign REF_BUF_EN           = act_q[2][REFBUF_LSB +: 2];
    // Divider is passed through; keeping it non-static while calibrating is up to software
    assign VCO_DIV_SEL          = act_q[4][VDIV_LSB +: 3];

    // Pin synchronisers
    logic lp_m_q, lp_s_q, sy_m_q, sy_s_q, sy_p_q;
    always_ff @(posedge CLK) begin
        if (RST) begin
            lp_m_q <= 1'b0;
            lp_s_q <= 1'b0;
            sy_m_q <= 1'b1;
            sy_s_q <= 1'b1;
            sy_p_q <= 1'b1;
        end else begin
            lp_m_q <= LOCK_DETECT_PIN;
            lp_s_q <= lp_m_q;
            sy_m_q <= SYNC_PIN_N;
            sy_s_q <= sy_m_q;
            sy_p_q <= sy_s_q;
        end
    end

    logic lock_lvl, sync_fall;
    assign lock_lvl  = cmp_en ? lp_s_q : 1'b1;
    assign sync_fall = sy_p_q && !sy_s_q;

    // Digital lock detect
    logic [7:0] dcnt_q, dcnt_d;
    logic       lkd_q, lkd_d;
    always_comb begin
        dcnt_d = dcnt_q;
        lkd_d  = lkd_q;
        if (lkd_dis) begin
            dcnt_d = 8'h00;
            lkd_d  = 1'b0;
        end else if (PFD_REF_EDGE) begin
            if (lkd_q) begin
                if (PFD_OVER_UNLOCK) begin
                    lkd_d = 1'b0;
                end
            end else if (PFD_IN_WINDOW) begin
                if (dcnt_q + 8'h01 >= phv_lock_need(lock_code)) begin
                    lkd_d  = 1'b1;
                    dcnt_d = 8'h00;
                end else begin
                    dcnt_d = dcnt_q + 8'h01;
                end
            end else begin
                dcnt_d = 8'h00;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            dcnt_q <= 8'h00;
            lkd_q  <= 1'b0;
        end else begin
            dcnt_q <= dcnt_d;
            lkd_q  <= lkd_d;
        end
    end
    assign DIGITAL_LOCK_DETECT = lkd_q;

    // Holdover: exit on a reference-path event (in manual mode only once the sync pin is high) or when holdover is disabled, which also covers switchover
    phv_hold_st_t hst_q, hst_d;
    logic         hiz_q, hiz_d, brst_q, brst_d;
    logic         ref_evt;
    assign ref_evt = PFD_REF_EDGE && REF_PRESENT;

    always_comb begin
        hst_d  = hst_q;
        brst_d = 1'b0;
        unique case (hst_q)
            HS_LOCKED: begin
                if (hold_en && hold_ext && sync_fall) begin
                    hst_d = HS_MANUAL;
                end else if (hold_en && !hold_ext && !lock_lvl) begin
                    hst_d = HS_AUTO;
                end
            end
            HS_AUTO: begin
                if (ref_evt) begin
                    hst_d  = HS_REARM;
                    brst_d = 1'b1;
                end
            end
            HS_MANUAL: begin
                if (ref_evt && sy_s_q) begin
                    hst_d  = HS_LOCKED;
                    brst_d = 1'b1;
                end
            end
            HS_REARM: begin
                if (lock_lvl) begin
                    hst_d = HS_LOCKED;
                end
            end
        endcase
        if (!hold_en) begin
            hst_d  = HS_LOCKED;
            brst_d = 1'b0;
        end
        hiz_d = (hst_d == HS_AUTO) || (hst_d == HS_MANUAL);
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            hst_q  <= HS_LOCKED;
            hiz_q  <= 1'b0;
            brst_q <= 1'b0;
        end else begin
            hst_q  <= hst_d;
            hiz_q  <= hiz_d;
            brst_q <= brst_d;
        end
    end
    assign CP_HIGHZ        = hiz_q;
    assign B_COUNTER_RESET = brst_q;

    // Frequency monitors: count edges per window, flag when below threshold
    logic [10:0] win_q, win_d;
    logic [7:0]  mcnt_q [3];
    logic [7:0]  mcnt_d [3];
    logic [2:0]  low_q, low_d;
    logic [7:0]  ref_thr;
    logic        vco_src;
    assign vco_src = CLKIN_SEL ? CLKIN_EDGE : VCO_EDGE;
    assign ref_thr = mon_ext ? MON_THR_EXT : MON_THR_NORMAL;

    always_comb begin
        win_d     = win_q + 11'h001;
        low_d     = low_q;
        mcnt_d[0] = sat_inc(mcnt_q[0], PRI_REF_EDGE);
        mcnt_d[1] = sat_inc(mcnt_q[1], SEC_REF_EDGE);
        mcnt_d[2] = sat_inc(mcnt_q[2], vco_src);
        if (win_q == MON_WINDOW_CYC - 11'h001) begin
            win_d    = 11'h000;
            low_d[0] = mcnt_q[0] < ref_thr;
            low_d[1] = mcnt_q[1] < ref_thr;
            low_d[2] = mcnt_q[2] < MON_THR_NORMAL;
            for (int i = 0; i < 3; i++) begin
                mcnt_d[i] = 8'h00;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            win_q <= 11'h000;
            low_q <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                mcnt_q[i] <= 8'h00;
            end
        end else begin
            win_q  <= win_d;
            low_q  <= low_d;
            mcnt_q <= mcnt_d;
        end
    end

    // Calibration sequencer
    phv_cal_if cif ();
    assign cif.start    = start_q;
    assign cif.div_sel  = act_q[0][CALDIV_LSB +: 2];
    assign cif.ref_edge = ref_evt;

    phv_cal_seq u_cal (
        .clk (CLK),
        .rst (RST),
        .cal (cif.cal)
    );
    assign OUTPUT_SYNC   = cif.output_sync;
    assign PLL_LOOP_OPEN = cif.loop_open;

    // Read data
    always_comb begin
        rdata_d = REG_RESET;
        if (REG_ADDR == ADDR_STAT) begin
            rdata_d = {1'b0, cif.done, lock_lvl, hiz_q, low_q, lkd_q};
        end else if (reg_index(REG_ADDR) != 3'h7) begin
            rdata_d = shad_q[reg_index(REG_ADDR)];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_q <= REG_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign REG_RDATA = rdata_q;

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_auto_unlock;
        hst_q == HS_LOCKED && hold_en && !hold_ext && !lock_lvl;
    endsequence

    a_hiz_on_unlock: assert property (
        s_auto_unlock |=> CP_HIGHZ)
        else $error("charge pump not high-Z after unlock");
    a_cmp_off_high: assert property (
        hst_q == HS_LOCKED && !cmp_en && !hold_ext |=> !CP_HIGHZ)
        else $error("holdover entered with comparator off");
    a_hiz_no_ref: assert property (
        CP_HIGHZ && hold_en && !ref_evt |=> CP_HIGHZ)
        else $error("charge pump left high-Z without reference");
    a_brst_on_exit: assert property (
        B_COUNTER_RESET |-> $past(CP_HIGHZ) && !CP_HIGHZ)
        else $error("B counter reset not aligned with high-Z exit");
    a_no_reenter: assert property (
        hst_q == HS_REARM && !lock_lvl && hold_en |=> !CP_HIGHZ)
        else $error("holdover re-entered before relock");
    a_lock_holds: assert property (
        PFD_REF_EDGE && lkd_q && !PFD_OVER_UNLOCK && !lkd_dis |=> DIGITAL_LOCK_DETECT)
        else $error("lock detect dropped without unlock cycle");
    a_hold_disabled: assert property (
        !hold_en |=> !CP_HIGHZ && !B_COUNTER_RESET)
        else $error("holdover active while disabled");
    a_cal_start: assert property (
        upd && shad_q[0][CAL_BIT] && !act_q[0][CAL_BIT] |=> ##1 OUTPUT_SYNC)
        else $error("calibration did not start on cal bit rise");
endmodule : phv_pll_ctrl

// >>> dv/phv_ref_src.sv
// Reference-side model: phase detector events and monitor edges for the control block.
// Assumes one shared clock; events are one-cycle pulses driven after each edge.
`timescale 1ns/1ns
module phv_ref_src (
    // Clock
    input  wire logic clk,
    // Controls from the bench
    input  wire logic en,
    input  wire logic win,
    input  wire logic over,
    input  wire logic mon_en,
    // Events toward the block
    output logic      pfd_edge,
    output logic      present,
    output logic      in_window,
    output logic      over_unlock,
    output logic      mon_edge
);
    logic tgl = 1'b0;
    // Idle qualifiers toggle so a stale level is never mistaken for a real one
    always @(posedge clk) begin
        tgl         <= ~tgl;
        pfd_edge    <= en;
        present     <= en;
        in_window   <= en ? win : tgl;
        over_unlock <= en ? over : tgl;
        mon_edge    <= mon_en & tgl;
    end
endmodule : phv_ref_src

// >>> dv/tb.sv
// Bench for the holdover and calibration control block, register-call tests.
// Assumes the reference model drives all phase detector and monitor edge inputs; the bench drives CLKIN_SEL.
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
    import phv_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, en = 1'b0, win = 1'b0, over = 1'b0;
    logic mon_en = 1'b0, lock_pin = 1'b1, sync_n = 1'b1, csel = 1'b0;
    logic [9:0] addr = 10'h000;
    logic [7:0] wdata = 8'h00, rdata, rv;
    logic pe, pr, pw, po, me, cphz, brst, lkd, hr, osync, lopen, cur, ras, rps;
    logic [5:0] ldm;
    logic [1:0] rbe;
    logic [2:0] vds;
    int err_count = 0, compares = 0, n, tick = 0;
    phv_ref_src i_src (.clk(clk), .en(en), .win(win), .over(over), .mon_en(mon_en),
        .pfd_edge(pe), .present(pr), .in_window(pw), .over_unlock(po), .mon_edge(me));
    phv_pll_ctrl i_dut (.CLK(clk), .RST(rst), .REG_WR(wr), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .PFD_REF_EDGE(pe), .PFD_IN_WINDOW(pw),
        .PFD_OVER_UNLOCK(po), .REF_PRESENT(pr), .LOCK_DETECT_PIN(lock_pin),
        .SYNC_PIN_N(sync_n), .PRI_REF_EDGE(me), .SEC_REF_EDGE(me), .VCO_EDGE(me),
        .CLKIN_EDGE(pe), .CLKIN_SEL(csel), .CP_HIGHZ(cphz), .B_COUNTER_RESET(brst),
        .DIGITAL_LOCK_DETECT(lkd), .LOCK_WIN_HIGH(hr), .OUTPUT_SYNC(osync),
        .PLL_LOOP_OPEN(lopen), .LOCK_PIN_MODE(ldm), .LOCK_PIN_CUR_SRC(cur),
        .REF_AUTO_SWITCH(ras), .REF_PREFER_SECONDARY(rps), .REF_BUF_EN(rbe),
        .VCO_DIV_SEL(vds));
    initial forever #25 clk = ~clk;
    // Whole run is about 16k cycles; the ceiling leaves ample margin
    always @(posedge clk) begin
        tick <= tick + 1;
        if (tick == 60000) begin
            err_count++;
            close_out();
        end
    end
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        cyc(2);
        d = rdata;
    endtask : rd_reg
    task automatic upd();
        wr_reg(ADDR_UPD, 8'h01);
    endtask : upd
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        cyc(10);
        rst <= 1'b0;
        cyc(3);
    endtask : do_reset
    task automatic close_out();
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    initial begin
        logic [9:0] regs [7];
        regs = '{ADDR_LDCAL, ADDR_LDPIN, ADDR_REFSEL, ADDR_HOLD, ADDR_STAT, ADDR_VDIV, 10'h0ff};
        do_reset();
        `CHK("high_range", 1'b1, hr)
        foreach (regs[i]) begin
            rd_reg(regs[i], rv);
            `CHK("reset_read", (regs[i] == ADDR_STAT) ? 8'h20 : 8'h00, rv)
        end
        wr_reg(10'h0ff, 8'hff);
        rd_reg(10'h0ff, rv);
        `CHK("unmapped", 8'h00, rv)
        // Lock detector: five in-window events needed, one over-threshold clears
        win <= 1'b1;
        en <= 1'b1;
        cyc(3);
        `CHK("lock_early", 1'b0, lkd)
        cyc(6);
        `CHK("lock_set", 1'b1, lkd)
        over <= 1'b1;
        cyc(1);
        over <= 1'b0;
        cyc(3);
        `CHK("lock_unlock", 1'b0, lkd)
        wr_reg(ADDR_LDCAL, 8'h18);
        upd();
        cyc(12);
        `CHK("lock_disabled", 1'b0, lkd)
        `CHK("low_range", 1'b0, hr)
        // First calibration with divider code 00 and events every cycle
        wr_reg(ADDR_VDIV, 8'h02);
        wr_reg(ADDR_LDPIN, 8'h04);
        wr_reg(ADDR_REFSEL, 8'h16);
        wr_reg(ADDR_LDCAL, 8'h01);
        upd();
        cyc(2);
        `CHK("sync_on", 1'b1, osync)
        `CHK("loop_open", 1'b1, lopen)
        `CHK("pin_mode", 6'h04, ldm)
        `CHK("cur_src", 1'b1, cur)
        `CHK("ref_ctrl", 4'hb, {ras, rps, rbe})
        `CHK("vco_div", 3'h2, vds)
        // The cycle already seen high counts as the first one
        for (n = 1; osync === 1'b1 && n < 9000; n++) cyc(1);
        `CHK("sync_cycles", 8798, n)
        `CHK("loop_still_open", 1'b1, lopen)
        for (n = 0; lopen === 1'b1 && n < 10; n++) cyc(1);
        `CHK("close_cycles", 2, n)
        rd_reg(ADDR_STAT, rv);
        `CHK("cal_done", 1'b1, rv[6])
        // Later calibration without reference: it must wait
        en <= 1'b0;
        wr_reg(ADDR_LDCAL, 8'h00);
        upd();
        wr_reg(ADDR_LDCAL, 8'h01);
        upd();
        rd_reg(ADDR_STAT, rv);
        `CHK("done_cleared", 1'b0, rv[6])
        cyc(200);
        `CHK("cal_waits", 2'b11, {osync, lopen})
        // Second reset in mid-run, then automatic holdover with the pin comparator
        do_reset();
        `CHK("reset_sync", 1'b0, osync)
        wr_reg(ADDR_HOLD, 8'h09);
        upd();
        lock_pin <= 1'b0;
        cyc(5);
        `CHK("hold_enter", 1'b1, cphz)
        cyc(30);
        `CHK("hold_no_ref", 1'b1, cphz)
        en <= 1'b1;
        for (n = 0; cphz === 1'b1 && n < 6; n++) cyc(1);
        `CHK("b_reset_with_exit", 2'b01, {cphz, brst})
        cyc(1);
        `CHK("b_reset_pulse", 1'b0, brst)
        en <= 1'b0;
        cyc(20);
        `CHK("rearm_wait", 1'b0, cphz)
        lock_pin <= 1'b1;
        cyc(4);
        lock_pin <= 1'b0;
        cyc(5);
        `CHK("re_enter", 1'b1, cphz)
        wr_reg(ADDR_HOLD, 8'h08);
        upd();
        cyc(2);
        `CHK("master_off", 1'b0, cphz)
        wr_reg(ADDR_HOLD, 8'h01);
        upd();
        cyc(10);
        rd_reg(ADDR_STAT, rv);
        `CHK("cmp_off", 2'b10, {rv[5], rv[4]})
        // Manual holdover: pin fall enters, exit waits for a reference event after pin high
        wr_reg(ADDR_HOLD, 8'h03);
        upd();
        sync_n <= 1'b0;
        cyc(5);
        `CHK("man_enter", 1'b1, cphz)
        sync_n <= 1'b1;
        cyc(10);
        `CHK("man_no_ref", 1'b1, cphz)
        en <= 1'b1;
        for (n = 0; cphz === 1'b1 && n < 6; n++) cyc(1);
        `CHK("man_exit", 2'b01, {cphz, brst})
        en <= 1'b0;
        // Frequency monitors: edges above threshold, then none
        mon_en <= 1'b1;
        cyc(2200);
        rd_reg(ADDR_STAT, rv);
        `CHK("mon_ok", 3'h0, rv[3:1])
        // Clock input selected while it has no edges: only that monitor flags
        csel <= 1'b1;
        cyc(2200);
        rd_reg(ADDR_STAT, rv);
        `CHK("clkin_low", 3'h4, rv[3:1])
        mon_en <= 1'b0;
        cyc(2200);
        rd_reg(ADDR_STAT, rv);
        `CHK("mon_low", 3'h7, rv[3:1])
        close_out();
    end
endmodule : tb
